// ### core/uls_pkg.sv
// Purpose: constants for the serial line status flags
// Assumes: 8-bit controller data space, 16-bit addresses
// Notes: bit positions and reset values of the status register
package uls_pkg;
    localparam logic [15:0] LINE_STATUS_ADDR = 16'hFFA5;
    localparam int OVERRUN_BIT = 0;
    localparam int PARITY_BIT = 1;
    localparam int FRAMING_BIT = 2;
    localparam int BREAK_BIT = 3;
    localparam int RX_FULL_BIT = 4;
    localparam int TX_EMPTY_BIT = 5;
    localparam int TX_IDLE_BIT = 6;
    localparam int RSV_BIT = 7;
    localparam logic [3:0] ERR_RESET = 4'h0;
    localparam logic RX_FULL_RESET = 1'b0;
    localparam logic TX_EMPTY_RESET = 1'b1;
    localparam logic TX_IDLE_RESET = 1'b1;
    localparam logic RSV_VALUE = 1'b0;
endpackage : uls_pkg

// ### core/uls_err_flag.sv
// Purpose: one sticky error flag, write-one-to-clear
// Assumes: single clock, asynchronous active-low reset
// Notes: a set in the clearing cycle wins
`timescale 1ns/100ps
`default_nettype none
module uls_err_flag
(
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic set_in,
    input wire logic clr_in,
    output logic flag_out
);
    typedef struct packed
    {
        logic flag;
    } uls_flag_state_t;

    uls_flag_state_t st_r;
    uls_flag_state_t st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        if (clr_in)
        begin
            st_nxt.flag = 1'b0; // R06
        end
        if (set_in)
        begin
            st_nxt.flag = 1'b1; // set beats clear so no error is lost
        end
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign flag_out = st_r.flag;
endmodule : uls_err_flag
`default_nettype wire

// ### core/uls_line_status.sv
// Contract
// R01: any error flag stalls serial DMA
// R02: overrun sets bit 0, requests interrupt
// R03: parity error sets bit 1, status interrupt
// R04: bad stop bit sets bit 2, status interrupt
// R05: break sets bit 3, status interrupt
// R06: error flags clear only on written one
// R07: bit 4 shows receive holding full, rx interrupt
// R08: bit 5 shows transmit holding empty, tx interrupt
// R09: bit 6 shows transmitter fully idle
// R10: register at FFA5h, bit 7 reads zero
// R11: errors set with the byte load
//
// Purpose: line status flags, DMA stall and interrupt requests
// Assumes: controller bus with address, read and write strobes, read data one cycle later
// Notes: shifters and interrupt enables live outside; events are one-cycle pulses
`timescale 1ns/100ps
`default_nettype none
module uls_line_status
#(
    parameter int ADDR_W = 16
)
(
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] rdata_out,
    input wire logic rx_load_in,
    input wire logic rx_overrun_in,
    input wire logic rx_parity_err_in,
    input wire logic rx_framing_err_in,
    input wire logic rx_break_in,
    input wire logic rx_read_in,
    input wire logic tx_write_in,
    input wire logic tx_shift_load_in,
    input wire logic tx_shift_done_in,
    input wire logic overrun_irq_en_in,
    input wire logic status_irq_en_in,
    input wire logic rx_irq_en_in,
    input wire logic tx_irq_en_in,
    output logic dma_stall_out,
    output logic overrun_irq_out,
    output logic status_irq_out,
    output logic rx_irq_out,
    output logic tx_irq_out
);
    // a narrower bus would alias the register onto other addresses
    generate
        if (ADDR_W < 16)
        begin : g_bad_addr_w
            $error("address width must hold the register address");
        end
    endgenerate

    typedef struct packed
    {
        logic rx_holding_full;
        logic tx_holding_empty;
        logic tx_shift_busy;
        logic [7:0] rdata;
        logic dma_stall;
        logic overrun_irq;
        logic status_irq;
        logic rx_irq;
        logic tx_irq;
    } uls_state_t;

    uls_state_t st_r;
    uls_state_t st_nxt;

    logic hit;
    logic wr_hit;
    logic [3:0] err_set;
    logic [3:0] err_flags;
    logic [3:0] err_nxt;
    logic [3:0] err_clr;
    logic err_any;
    logic err_status_any;
    logic [7:0] status_nxt;

    assign hit = (addr_in == ADDR_W'(uls_pkg::LINE_STATUS_ADDR)); // R10
    assign wr_hit = hit & wr_en_in;

    // errors are qualified by the byte load so they land with the byte
    assign err_set[uls_pkg::OVERRUN_BIT] = rx_load_in & rx_overrun_in; // R02 R11
    assign err_set[uls_pkg::PARITY_BIT] = rx_load_in & rx_parity_err_in; // R03 R11
    assign err_set[uls_pkg::FRAMING_BIT] = rx_load_in & rx_framing_err_in; // R04 R11
    assign err_set[uls_pkg::BREAK_BIT] = rx_load_in & rx_break_in; // R05 R11

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_err
            uls_err_flag u_flag
            (
                .ref_clk_in(ref_clk_in),
                .nrst_in(nrst_in),
                .set_in(err_set[gi]),
                .clr_in(err_clr[gi]), // R06
                .flag_out(err_flags[gi])
            );
            // only a written one clears; a written zero leaves the flag alone
            assign err_clr[gi] = wr_hit & wdata_in[gi]; // R06
            // next value mirrors the flag module so outputs stay registered here
            assign err_nxt[gi] = err_set[gi] | (err_flags[gi] & ~err_clr[gi]);
        end
    endgenerate

    assign err_any = |err_nxt; // R01
    assign err_status_any = |err_nxt[uls_pkg::BREAK_BIT:uls_pkg::PARITY_BIT]; // R03 R04 R05

    always_comb
    begin
        st_nxt = st_r;
        // a new byte wins over the read that drains the old one
        if (rx_read_in)
        begin
            st_nxt.rx_holding_full = 1'b0;
        end
        if (rx_load_in)
        begin
            st_nxt.rx_holding_full = 1'b1; // R07
        end
        if (tx_shift_load_in)
        begin
            st_nxt.tx_holding_empty = 1'b1; // R08
            st_nxt.tx_shift_busy = 1'b1;
        end
        else if (tx_shift_done_in)
        begin
            st_nxt.tx_shift_busy = 1'b0;
        end
        if (tx_write_in)
        begin
            st_nxt.tx_holding_empty = 1'b0; // R08
        end
        status_nxt = 8'h00;
        status_nxt[3:0] = err_nxt;
        status_nxt[uls_pkg::RX_FULL_BIT] = st_nxt.rx_holding_full; // R07
        status_nxt[uls_pkg::TX_EMPTY_BIT] = st_nxt.tx_holding_empty; // R08
        status_nxt[uls_pkg::TX_IDLE_BIT] = st_nxt.tx_holding_empty
            & ~st_nxt.tx_shift_busy; // R09
        status_nxt[uls_pkg::RSV_BIT] = uls_pkg::RSV_VALUE; // R10
        if (rd_en_in && hit)
        begin
            st_nxt.rdata = status_nxt; // R10
        end
        else
        begin
            st_nxt.rdata = 8'h00;
        end
        st_nxt.dma_stall = err_any; // R01
        st_nxt.overrun_irq = err_nxt[uls_pkg::OVERRUN_BIT] & overrun_irq_en_in; // R02
        st_nxt.status_irq = err_status_any & status_irq_en_in; // R03 R04 R05
        st_nxt.rx_irq = st_nxt.rx_holding_full & rx_irq_en_in; // R07
        st_nxt.tx_irq = st_nxt.tx_holding_empty & tx_irq_en_in; // R08
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            st_r.rx_holding_full <= uls_pkg::RX_FULL_RESET;
            st_r.tx_holding_empty <= uls_pkg::TX_EMPTY_RESET; // R08
            st_r.tx_shift_busy <= ~uls_pkg::TX_IDLE_RESET; // R09
            st_r.rdata <= 8'h00;
            st_r.dma_stall <= 1'b0;
            st_r.overrun_irq <= 1'b0;
            st_r.status_irq <= 1'b0;
            st_r.rx_irq <= 1'b0;
            st_r.tx_irq <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign rdata_out = st_r.rdata;
    assign dma_stall_out = st_r.dma_stall;
    assign overrun_irq_out = st_r.overrun_irq;
    assign status_irq_out = st_r.status_irq;
    assign rx_irq_out = st_r.rx_irq;
    assign tx_irq_out = st_r.tx_irq;
endmodule : uls_line_status
`default_nettype wire

// ### testbench/uls_checker.sv
// Purpose: port checks of the line status block
// Assumes: one clock, async active-low reset
// Notes: error flags are seen only through reads and outputs
`timescale 1ns/100ps
`default_nettype none
module uls_checker
(
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic [15:0] addr_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    input wire logic [7:0] rdata_out,
    input wire logic rx_load_in,
    input wire logic rx_parity_err_in,
    input wire logic rx_break_in,
    input wire logic tx_write_in,
    input wire logic tx_shift_load_in,
    input wire logic rx_irq_en_in,
    input wire logic dma_stall_out,
    input wire logic rx_irq_out,
    input wire logic tx_irq_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);
    wire logic hit = addr_in == uls_pkg::LINE_STATUS_ADDR;
    sequence s_brk; rd_en_in && hit && rx_load_in && rx_break_in; endsequence
    sequence s_txw; tx_write_in ##1 (rd_en_in && hit && !tx_shift_load_in); endsequence
    property p_stall; rx_load_in && rx_parity_err_in |=> dma_stall_out; endproperty
    a_stall: assert property (p_stall) else $error("no stall");
    property p_keep; dma_stall_out && !(wr_en_in && hit) |=> dma_stall_out; endproperty
    a_keep: assert property (p_keep) else $error("flag lost");
    property p_rsv; rdata_out[7] == 1'b0; endproperty
    a_rsv: assert property (p_rsv) else $error("bit 7 set");
    property p_other; !(rd_en_in && hit) |=> rdata_out == 8'h00; endproperty
    a_other: assert property (p_other) else $error("stray read data");
    property p_rx; rx_load_in && rx_irq_en_in |=> rx_irq_out; endproperty
    a_rx: assert property (p_rx) else $error("no rx irq");
    property p_tx; tx_write_in |=> !tx_irq_out; endproperty
    a_tx: assert property (p_tx) else $error("tx irq high");
    property p_brk; s_brk |=> rdata_out[3] && rdata_out[4]; endproperty
    a_brk: assert property (p_brk) else $error("break late");
    property p_idle; s_txw |=> !rdata_out[6] && !rdata_out[5]; endproperty
    a_idle: assert property (p_idle) else $error("tx not busy");
endmodule : uls_checker
bind uls_line_status uls_checker u_uls_checker (.*);
`default_nettype wire

// ### testbench/uls_dma_model.sv
// Purpose: dma side, drains the receive holding byte
// Assumes: rx irq enabled, so it mirrors holding full
// Notes: one take per byte; never takes while stalled
`timescale 1ns/100ps
`default_nettype none
module uls_dma_model
(
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic full_in,
    input wire logic stall_in,
    output logic take_out
);
    always_ff @(posedge ref_clk_in or negedge nrst_in)
        if (!nrst_in)
            take_out <= 1'b0;
        else
            take_out <= full_in && !stall_in && !take_out;
endmodule : uls_dma_model
`default_nettype wire

// ### testbench/tb_top.sv
// Purpose: self-checking bench of the line status block
// Assumes: inputs move 1 ns after the rising edge
// Notes: interrupt enables held high except while t_misc drives them low
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    localparam logic [15:0] la = uls_pkg::LINE_STATUS_ADDR;
    logic ref_clk_in = 1'b0, nrst_in = 1'b0, wr_en_in = 1'b0, rd_en_in = 1'b0;
    logic rx_load_in = 1'b0, rx_overrun_in = 1'b0, rx_parity_err_in = 1'b0;
    logic rx_framing_err_in = 1'b0, rx_break_in = 1'b0, tx_write_in = 1'b0;
    logic tx_shift_load_in = 1'b0, tx_shift_done_in = 1'b0, rx_read_in;
    logic overrun_irq_en_in = 1'b1, status_irq_en_in = 1'b1;
    logic rx_irq_en_in = 1'b1, tx_irq_en_in = 1'b1;
    logic [15:0] addr_in = 16'h0000;
    logic [7:0] wdata_in = 8'h00, rdata_out;
    logic dma_stall_out, overrun_irq_out, status_irq_out, rx_irq_out, tx_irq_out;
    int n_errors = 0, tests_run = 0, cyc = 0;
    uls_line_status u_uls_line_status (.*);
    uls_dma_model u_uls_dma_model (.ref_clk_in, .nrst_in, .full_in(rx_irq_out),
        .stall_in(dma_stall_out), .take_out(rx_read_in));
    initial forever #5 ref_clk_in = ~ref_clk_in;
    task complete_run;
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run
    task ck(input string n, input logic [7:0] e, input logic [7:0] s);
        tests_run++;
        if (s !== e)
        begin
            n_errors++;
            $display("mismatch %s exp %h got %h", n, e, s);
        end
    endtask : ck
    task rd(input logic [15:0] a, input logic [7:0] e);
        addr_in = a;
        rd_en_in = 1'b1;
        @(posedge ref_clk_in) #1 rd_en_in = 1'b0;
        ck("rdata", e, rdata_out);
    endtask : rd
    task wr(input logic [7:0] d);
        addr_in = la;
        wdata_in = d;
        wr_en_in = 1'b1;
        @(posedge ref_clk_in) #1 wr_en_in = 1'b0;
    endtask : wr
    task ev(input logic [2:0] t);
        {tx_shift_done_in, tx_shift_load_in, tx_write_in} = t;
        @(posedge ref_clk_in) #1 {tx_shift_done_in, tx_shift_load_in, tx_write_in} = 3'h0;
    endtask : ev
    task t_err;
        for (int i = 0; i < 4; i++)
        begin
            {rx_break_in, rx_framing_err_in, rx_parity_err_in, rx_overrun_in} = 4'h1 << i;
            rx_load_in = 1'b1;
            @(posedge ref_clk_in) #1 rx_load_in = 1'b0;
            ck("stall", 8'h01, {7'h00, dma_stall_out});
            ck("irq", (i == 0) ? 8'h01 : 8'h02, {6'h00, status_irq_out, overrun_irq_out});
            rd(la, 8'h70 | (8'h01 << i));
            wr(8'hF0);
            ck("hold", 8'h01, {7'h00, dma_stall_out});
            wr(8'h01 << i);
            ck("clear", 8'h00, {7'h00, dma_stall_out});
            repeat (3) @(posedge ref_clk_in) #1;
            rd(la, 8'h60);
        end
        {rx_break_in, rx_framing_err_in, rx_parity_err_in, rx_overrun_in} = 4'h0;
        $display("t_err done");
    endtask : t_err
    task t_same;
        rx_break_in = 1'b1;
        rx_load_in = 1'b1;
        rd(la, 8'h78);
        rx_load_in = 1'b0;
        rx_break_in = 1'b0;
        wr(8'h08);
        repeat (3) @(posedge ref_clk_in) #1;
        rd(la, 8'h60);
        $display("t_same done");
    endtask : t_same
    task t_tx;
        ev(3'h1);
        ck("txirq", 8'h00, {7'h00, tx_irq_out});
        rd(la, 8'h00);
        ev(3'h2);
        rd(la, 8'h20);
        ev(3'h4);
        rd(la, 8'h60);
        ck("txirq", 8'h01, {7'h00, tx_irq_out});
        $display("t_tx done");
    endtask : t_tx
    task t_misc;
        overrun_irq_en_in = 1'b0;
        status_irq_en_in = 1'b0;
        rx_irq_en_in = 1'b0;
        tx_irq_en_in = 1'b0;
        rx_parity_err_in = 1'b1;
        rx_overrun_in = 1'b1;
        rx_load_in = 1'b1;
        @(posedge ref_clk_in) #1 rx_load_in = 1'b0;
        rx_parity_err_in = 1'b0;
        rx_overrun_in = 1'b0;
        ck("irq_off", 8'h00, {4'h0, tx_irq_out, rx_irq_out, status_irq_out, overrun_irq_out});
        ck("stall_off", 8'h01, {7'h00, dma_stall_out});
        addr_in = 16'hFFA6;
        wdata_in = 8'h03;
        wr_en_in = 1'b1;
        @(posedge ref_clk_in) #1 wr_en_in = 1'b0;
        rd(la, 8'h73);
        wr(8'h03);
        rd(la, 8'h70);
        overrun_irq_en_in = 1'b1;
        status_irq_en_in = 1'b1;
        rx_irq_en_in = 1'b1;
        tx_irq_en_in = 1'b1;
        repeat (4) @(posedge ref_clk_in) #1;
        rd(la, 8'h60);
        ck("irq_on", 8'h08, {4'h0, tx_irq_out, rx_irq_out, status_irq_out, overrun_irq_out});
        $display("t_misc done");
    endtask : t_misc
    always @(posedge ref_clk_in)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_errors++;
            complete_run;
        end
    end
    initial
    begin
        repeat (3) @(posedge ref_clk_in);
        #1 nrst_in = 1'b1;
        rd(la, 8'h60);
        rd(16'hFFA6, 8'h00);
        $display("t_base done");
        t_err;
        t_same;
        t_tx;
        t_misc;
        complete_run;
    end
endmodule : tb_top
`default_nettype wire
